// ### hw/spdif_conceal_rate.sv
// parity concealment, c/u delay, error and sample rate meter
`timescale 1ns/1ps
`include "spdif_rx_map.svh"
`default_nettype none
module spdif_conceal_rate
    import spdif_rx_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // pins from outside the clock domain
    input wire logic reference_clock_input,
    input wire logic frame_clock,
    input wire logic bit_clock,
    input wire logic pll_lock,
    // decoded subframes from the biphase decoder, same clock
    input wire logic sf_valid,
    input wire logic sf_channel,
    input wire logic [23:0] sf_data,
    input wire logic sf_parity_err,
    input wire logic sf_status_bit,
    input wire logic sf_user_bit,
    input wire logic block_start_pulse,
    // processed audio words
    output logic audio_valid,
    output logic audio_channel,
    output logic [23:0] audio_data,
    // channel-status and user serial bits
    output logic status_bit_output,
    output logic user_bit_output,
    // error, rate code and clock source select
    output logic error_out,
    output logic rate_code_bit_high,
    output logic rate_code_bit_low,
    output logic use_free_running
);
    localparam logic [17:0] C32_LO = 18'(`CNT_LO(`FS32_HI_HZ));
    localparam logic [17:0] C32_HI = 18'(`CNT_HI(`FS32_LO_HZ));
    localparam logic [17:0] C44_LO = 18'(`CNT_LO(`FS44_HI_HZ));
    localparam logic [17:0] C44_HI = 18'(`CNT_HI(`FS44_LO_HZ));
    localparam logic [17:0] C48_LO = 18'(`CNT_LO(`FS48_HI_HZ));
    localparam logic [17:0] C48_HI = 18'(`CNT_HI(`FS48_LO_HZ));
    localparam logic [12:0] PER_MAX = 13'(`PERIOD_MAX_CYC);
    localparam logic [12:0] PER_MIN = 13'(`PERIOD_MIN_CYC);
    localparam logic [7:0] STOP_CYC = 8'(`REF_STOP_CYC);
    localparam logic [6:0] FRAMES = 7'(`RATE_FRAMES);
    localparam logic [4:0] CU_DELAY = 5'(`CU_DELAY_BCK);

    logic [3:0] pins_s;
    logic ref_s;
    logic fck_s;
    logic bck_s;
    logic lock_s;
    logic ref_d_r;
    logic fck_d_r;
    logic bck_d_r;
    logic ref_edge;
    logic fck_rise;
    logic fck_any;
    logic bck_rise;

    logic [31:0] ctrl_r;
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic [31:0] rd_nxt;

    logic [12:0] per_cnt_r;
    logic [12:0] per_prev_r;
    logic per_prev_ok_r;
    logic span_bad_r;
    logic jump_r;
    logic unlock_r;
    logic [12:0] per_diff;

    logic [7:0] stop_cnt_r;
    logic ref_seen_r;
    logic ref_run;
    meter_state_t ms_r;
    logic [6:0] frm_cnt_r;
    logic [17:0] ref_cnt_r;
    logic [17:0] last_cnt_r;
    rate_code_t rate_r;
    rate_code_t rate_nxt;

    logic [7:0] fidx_r;
    logic [7:0] fidx_cur;
    logic [1:0] nonpcm_r;
    logic [23:0] last_good_r [0:1];
    logic parity_hold_r;

    logic pend_c_r;
    logic pend_u_r;
    logic stage_c_r;
    logic stage_u_r;
    logic [4:0] cu_cnt_r;

    // all four pins cross into clk before use
    sync2 #(.W(4)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .din({pll_lock, bit_clock, frame_clock, reference_clock_input}),
        .dout(pins_s)
    );
    assign ref_s = pins_s[0];
    assign fck_s = pins_s[1];
    assign bck_s = pins_s[2];
    assign lock_s = pins_s[3];

    // edge history of the synchronised reference, frame and bit clock pins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ref_d_r <= 1'b0;
            fck_d_r <= 1'b0;
            bck_d_r <= 1'b0;
        end else begin
            ref_d_r <= ref_s;
            fck_d_r <= fck_s;
            bck_d_r <= bck_s;
        end
    end
    // reference is sampled at 100 mhz, so only its rising edges count
    assign ref_edge = ref_s & ~ref_d_r;
    assign fck_rise = fck_s & ~fck_d_r;
    assign fck_any = fck_s ^ fck_d_r;
    assign bck_rise = bck_s & ~bck_d_r;

    // ahb-lite: zero wait states, always okay
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // read data is sampled in the address phase, one cycle old values
    always_comb begin
        rd_nxt = 32'h0000_0000;
        unique case (haddr[7:0])
            `REG_CTRL: rd_nxt = ctrl_r;
            `REG_STATUS: begin
                rd_nxt[`ST_RATE_LSB +: 2] = rate_r;
                rd_nxt[`ST_UNLOCK_BIT] = unlock_r;
                rd_nxt[`ST_ERROR_BIT] = error_out;
                rd_nxt[`ST_REF_SEEN_BIT] = ref_seen_r;
                rd_nxt[`ST_REF_RUN_BIT] = ref_run;
                rd_nxt[`ST_NONPCM_LSB +: 2] = nonpcm_r;
            end
            `REG_COUNT: rd_nxt[17:0] = last_cnt_r;
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    // address phase capture and data phase write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata <= 32'h0000_0000;
            ctrl_r <= `CTRL_RESET;
        end else begin
            if (hready) begin
                wr_pend_r <= hsel & htrans[1] & hwrite;
                wr_addr_r <= haddr[7:0];
                if (hsel && htrans[1] && !hwrite) begin
                    hrdata <= rd_nxt;
                end
            end
            if (wr_pend_r && wr_addr_r == `REG_CTRL) begin
                ctrl_r <= {31'h0000_0000, hwdata[`CTRL_RECOVERED_BIT]};
            end
        end
    end

    // frame period check: span, step and a stalled frame clock
    assign per_diff = (per_cnt_r > per_prev_r) ? per_cnt_r - per_prev_r
                                               : per_prev_r - per_cnt_r;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            per_cnt_r <= 13'h0000;
            per_prev_r <= 13'h0000;
            per_prev_ok_r <= 1'b0;
            span_bad_r <= 1'b1;
            jump_r <= 1'b0;
        end else if (fck_rise) begin
            per_cnt_r <= 13'h0001;
            per_prev_r <= per_cnt_r;
            per_prev_ok_r <= 1'b1;
            span_bad_r <= per_cnt_r > PER_MAX || per_cnt_r < PER_MIN;
            // more than one eighth of a period between frames
            jump_r <= per_prev_ok_r && per_diff > (per_prev_r >> 3);
        end else begin
            if (per_cnt_r != 13'h1fff) begin
                per_cnt_r <= per_cnt_r + 13'h0001;
            end
            if (per_cnt_r > PER_MAX) begin
                span_bad_r <= 1'b1;
                per_prev_ok_r <= 1'b0;
            end
        end
    end

    // unlock seen by meter, error pin and clock select
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            unlock_r <= 1'b1;
        end else begin
            unlock_r <= ~lock_s | span_bad_r | jump_r;
        end
    end

    // reference activity: ever seen, and still running
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stop_cnt_r <= STOP_CYC;
            ref_seen_r <= 1'b0;
        end else if (ref_edge) begin
            stop_cnt_r <= 8'h00;
            ref_seen_r <= 1'b1;
        end else if (stop_cnt_r != STOP_CYC) begin
            stop_cnt_r <= stop_cnt_r + 8'h01;
        end
    end
    // a grounded reference never starts this
    assign ref_run = ref_seen_r && stop_cnt_r != STOP_CYC;

    // code from the count alone, never from channel-status fields
    always_comb begin
        rate_nxt = `RATE_ABNORMAL;
        if (ref_cnt_r >= C32_LO && ref_cnt_r <= C32_HI) begin
            rate_nxt = `RATE_32K;
        end else if (ref_cnt_r >= C44_LO && ref_cnt_r <= C44_HI) begin
            rate_nxt = `RATE_44K;
        end else if (ref_cnt_r >= C48_LO && ref_cnt_r <= C48_HI) begin
            rate_nxt = `RATE_48K;
        end
    end

    // rate meter: reference edges over a window of frame periods
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ms_r <= MS_WAIT;
            frm_cnt_r <= 7'h00;
            ref_cnt_r <= 18'h00000;
            last_cnt_r <= 18'h00000;
            rate_r <= `RATE_RESET;
        end else if (!ref_run) begin
            ms_r <= MS_WAIT;
        end else if (unlock_r) begin
            ms_r <= MS_WAIT;
            rate_r <= `RATE_ABNORMAL;
        end else begin
            unique case (ms_r)
                MS_WAIT: begin
                    ms_r <= MS_ARM;
                end
                MS_ARM: begin
                    if (fck_rise) begin
                        ms_r <= MS_COUNT;
                        frm_cnt_r <= 7'h00;
                        ref_cnt_r <= 18'h00000;
                    end
                end
                MS_COUNT: begin
                    if (ref_edge && ref_cnt_r != 18'h3ffff) begin
                        ref_cnt_r <= ref_cnt_r + 18'h00001;
                    end
                    if (fck_rise) begin
                        if (frm_cnt_r == FRAMES - 7'h01) begin
                            // window done: publish and start again
                            last_cnt_r <= ref_cnt_r;
                            rate_r <= rate_nxt;
                            frm_cnt_r <= 7'h00;
                            ref_cnt_r <= 18'h00000;
                        end else begin
                            frm_cnt_r <= frm_cnt_r + 7'h01;
                        end
                    end
                end
            endcase
        end
    end

    // rate code pins straight from the held result
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rate_code_bit_high <= 1'b0;
            rate_code_bit_low <= 1'b0;
        end else begin
            rate_code_bit_high <= rate_r[1];
            rate_code_bit_low <= rate_r[0];
        end
    end

    // frame index inside the channel-status block
    assign fidx_cur = (sf_channel == 1'b0)
                    ? (block_start_pulse ? 8'h00 : fidx_r + 8'h01)
                    : fidx_r;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fidx_r <= 8'h00;
            nonpcm_r <= 2'b00;
        end else if (sf_valid) begin
            fidx_r <= fidx_cur;
            if (fidx_cur == `CS_NONPCM_BIT) begin
                nonpcm_r[sf_channel] <= sf_status_bit;
            end
        end
    end

    // concealment: holding the last good word is the simplest
    // interpolation and never invents values outside the signal
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            audio_valid <= 1'b0;
            audio_channel <= 1'b0;
            audio_data <= 24'h000000;
            last_good_r[0] <= 24'h000000;
            last_good_r[1] <= 24'h000000;
        end else begin
            audio_valid <= sf_valid;
            if (sf_valid) begin
                audio_channel <= sf_channel;
                if (sf_parity_err && !nonpcm_r[sf_channel]) begin
                    audio_data <= last_good_r[sf_channel];
                end else begin
                    audio_data <= sf_data;
                end
                if (!sf_parity_err) begin
                    last_good_r[sf_channel] <= sf_data;
                end
            end
        end
    end

    // parity error held to the next frame transition, set wins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            parity_hold_r <= 1'b0;
        end else if (sf_valid && sf_parity_err) begin
            parity_hold_r <= 1'b1;
        end else if (fck_any) begin
            parity_hold_r <= 1'b0;
        end
    end

    // error pin and clock source select
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            error_out <= 1'b1;
            use_free_running <= 1'b0;
        end else begin
            error_out <= unlock_r | parity_hold_r;
            use_free_running <= ctrl_r[`CTRL_RECOVERED_BIT]
                              & (unlock_r | parity_hold_r);
        end
    end

    // latest subframe's c and u bits wait for the frame transition
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pend_c_r <= 1'b0;
            pend_u_r <= 1'b0;
        end else if (sf_valid) begin
            pend_c_r <= sf_status_bit;
            pend_u_r <= sf_user_bit;
        end
    end

    // c/u update a fixed count of bit clocks after each transition;
    // a new transition before the count ends restarts it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stage_c_r <= 1'b0;
            stage_u_r <= 1'b0;
            cu_cnt_r <= 5'h00;
            status_bit_output <= 1'b0;
            user_bit_output <= 1'b0;
        end else if (fck_any) begin
            stage_c_r <= pend_c_r;
            stage_u_r <= pend_u_r;
            cu_cnt_r <= CU_DELAY;
        end else if (bck_rise && cu_cnt_r != 5'h00) begin
            cu_cnt_r <= cu_cnt_r - 5'h01;
            if (cu_cnt_r == 5'h01) begin
                status_bit_output <= stage_c_r;
                user_bit_output <= stage_u_r;
            end
        end
    end

    // word-only bus: size is not checked
    logic unused_ok;
    assign unused_ok = ^{hsize, haddr[31:8], hwdata[31:1]};
endmodule : spdif_conceal_rate
`default_nettype wire

// ### hw/spdif_rx_map.svh
// offsets, field positions, reset values and timing counts of the receiver
`ifndef SPDIF_RX_MAP_SVH
`define SPDIF_RX_MAP_SVH

// register byte offsets on the bus (decoded on haddr[7:0])
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_COUNT 8'h08

// control fields
`define CTRL_RECOVERED_BIT 0
`define CTRL_RESET 32'h0000_0001

// status fields
`define ST_RATE_LSB 0
`define ST_UNLOCK_BIT 2
`define ST_ERROR_BIT 3
`define ST_REF_SEEN_BIT 4
`define ST_REF_RUN_BIT 5
`define ST_NONPCM_LSB 6

// rate codes {bit_high, bit_low}
`define RATE_ABNORMAL 2'h2
`define RATE_32K 2'h3
`define RATE_44K 2'h0
`define RATE_48K 2'h1
`define RATE_RESET 2'h0

// channel-status bit that marks non-pcm words
`define CS_NONPCM_BIT 8'h01

// clock and measurement timebase
`define CLK_PERIOD_NS 10
`define CLK_HZ 100000000
`define REF_HZ 24576000
`define RATE_FRAMES 64

// ranges of the rate code, in hz
`define FS32_LO_HZ 31200
`define FS32_HI_HZ 32800
`define FS44_LO_HZ 43000
`define FS44_HI_HZ 45200
`define FS48_LO_HZ 46800
`define FS48_HI_HZ 49200

// reference counts over the measuring window (low bound up, high down)
`define CNT_LO(hz) ((`REF_HZ * `RATE_FRAMES + (hz) - 1) / (hz))
`define CNT_HI(hz) ((`REF_HZ * `RATE_FRAMES) / (hz))

// accepted input span, hz, and frame period limits in clk cycles
`define FS_MIN_HZ 28000
`define FS_MAX_HZ 108000
`define PERIOD_MAX_CYC (`CLK_HZ / `FS_MIN_HZ)
`define PERIOD_MIN_CYC ((`CLK_HZ + `FS_MAX_HZ - 1) / `FS_MAX_HZ)

// reference clock considered stopped after this long without an edge
`define REF_STOP_NS 1000
`define REF_STOP_CYC ((`REF_STOP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// bit-clock periods between a frame-clock transition and c/u update
`define CU_DELAY_BCK 17

`endif

// ### hw/spdif_rx_pkg.sv
// types shared by the receiver modules
package spdif_rx_pkg;
    // rate meter sequence
    typedef enum logic [2:0] {
        MS_WAIT = 3'b001,
        MS_ARM = 3'b010,
        MS_COUNT = 3'b100
    } meter_state_t;

    typedef logic [1:0] rate_code_t;
endpackage : spdif_rx_pkg

// ### hw/sync2.sv
// two flip-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // asynchronous in, synchronous out
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_r;

    // first stage is read only by the second
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_r <= '0;
            dout <= '0;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule : sync2
`default_nettype wire

// ### verification/spdif_conceal_rate_chk.sv
// concurrent checks on the receiver ports
`timescale 1ns/1ps
`default_nettype none
module spdif_conceal_rate_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins
    input wire logic reference_clock_input,
    input wire logic frame_clock,
    input wire logic bit_clock,
    input wire logic pll_lock,
    // subframes in, audio out
    input wire logic sf_valid,
    input wire logic [23:0] sf_data,
    input wire logic sf_parity_err,
    input wire logic audio_valid,
    input wire logic [23:0] audio_data,
    // status outputs
    input wire logic status_bit_output,
    input wire logic user_bit_output,
    input wire logic error_out,
    input wire logic rate_code_bit_high,
    input wire logic rate_code_bit_low
);
    logic [7:0] ref_idle_r;
    logic [3:0] ref_cnt_r;
    logic [4:0] bck_cnt_r;
    logic ref_d_r;
    logic bck_d_r;
    logic fr_d_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // raw pin history, saturating counts
    always_ff @(posedge clk) begin
        ref_d_r <= reference_clock_input;
        bck_d_r <= bit_clock;
        fr_d_r <= frame_clock;
        if (!rst_n) begin
            ref_idle_r <= 8'h00;
            ref_cnt_r <= 4'h0;
            bck_cnt_r <= 5'h00;
        end else begin
            if (reference_clock_input != ref_d_r) begin
                ref_idle_r <= 8'h00;
                if (ref_cnt_r != 4'hf) ref_cnt_r <= ref_cnt_r + 4'h1;
            end else if (ref_idle_r != 8'hff) begin
                ref_idle_r <= ref_idle_r + 8'h01;
            end
            if (frame_clock != fr_d_r) bck_cnt_r <= 5'h00;
            else if (bit_clock && !bck_d_r && bck_cnt_r != 5'h1f)
                bck_cnt_r <= bck_cnt_r + 5'h01;
        end
    end

    a_audio_pulse: assert property (
        audio_valid == $past(sf_valid)) else $error("audio pulse misplaced");
    a_good_pass: assert property (
        sf_valid && !sf_parity_err |=> audio_data == $past(sf_data))
        else $error("clean word altered");
    a_parity_flag: assert property (
        sf_valid && sf_parity_err |-> ##2 error_out)
        else $error("parity error not flagged");
    a_unlock_err: assert property (
        !pll_lock [*8] |-> error_out) else $error("unlock not flagged");
    a_unlock_code: assert property (
        (!pll_lock && ref_idle_r < 8'd20 && ref_cnt_r == 4'hf) [*8] |-> ##2
        {rate_code_bit_high, rate_code_bit_low} == 2'b10)
        else $error("unlocked rate code not abnormal");
    a_no_ref_low: assert property (
        ref_cnt_r == 4'h0 |-> !rate_code_bit_high && !rate_code_bit_low)
        else $error("rate code set without reference");
    a_rate_freeze: assert property (
        ref_idle_r > 8'd150 |->
        $stable({rate_code_bit_high, rate_code_bit_low}))
        else $error("rate code moved with reference stopped");
    a_cu_delay: assert property (
        $changed({status_bit_output, user_bit_output}) |->
        bck_cnt_r inside {[5'd15:5'd18]}) else $error("c/u changed off time");

    c_rate_48: cover property (!rate_code_bit_high && rate_code_bit_low);
    c_parity: cover property (sf_valid && sf_parity_err);
    c_cu: cover property ($changed(user_bit_output));
endmodule : spdif_conceal_rate_chk

bind spdif_conceal_rate spdif_conceal_rate_chk chk_u (.clk, .rst_n,
    .reference_clock_input, .frame_clock, .bit_clock, .pll_lock, .sf_valid,
    .sf_data, .sf_parity_err, .audio_valid, .audio_data, .status_bit_output,
    .user_bit_output, .error_out, .rate_code_bit_high, .rate_code_bit_low);
`default_nettype wire

// ### verification/audio_src_model.sv
// source side: clocks, lock, subframes, reference
`timescale 1ns/1ps
`default_nettype none
module audio_src_model #(
    parameter int BLOCK = 4
) (
    // clock, reset and scenario controls
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [11:0] period,
    input wire logic ref_en,
    input wire logic lock_en,
    input wire logic cs_bit,
    input wire logic [1:0] perr,
    // pins and subframes towards the receiver
    output logic reference_clock_input,
    output logic frame_clock,
    output logic bit_clock,
    output logic pll_lock,
    output logic sf_valid,
    output logic sf_channel,
    output logic [23:0] sf_data,
    output logic sf_parity_err,
    output logic sf_status_bit,
    output logic sf_user_bit,
    output logic block_start_pulse
);
    logic [11:0] pos_r = 12'h000;
    logic [22:0] fcnt_r = 23'h0;
    wire logic ch = pos_r >= (period >> 1);
    wire logic hit = pos_r == 12'd8 || pos_r == (period >> 1) + 12'd8;

    // 40 mhz stand-in timebase shortens a window
    initial begin
        reference_clock_input = 1'b0;
        #3.1;
        forever begin
            #12.5;
            reference_clock_input = ref_en ? ~reference_clock_input : 1'b0;
        end
    end

    // quiet outputs until the first edge
    initial begin
        {frame_clock, bit_clock, pll_lock, sf_valid, sf_channel, sf_data,
         sf_parity_err, sf_status_bit, sf_user_bit, block_start_pulse} = '0;
    end

    // frame position, clocks, one subframe per half
    always @(posedge clk) begin
        if (!rst_n || pos_r >= period - 12'd1) pos_r <= 12'h000;
        else pos_r <= pos_r + 12'h001;
        if (!rst_n) fcnt_r <= 23'h0;
        else if (hit && ch) fcnt_r <= fcnt_r + 23'h1;
        frame_clock <= !ch;
        bit_clock <= (pos_r % (period >> 6)) < (period >> 7);
        pll_lock <= lock_en;
        sf_valid <= rst_n && hit;
        if (rst_n && hit) begin
            sf_channel <= ch;
            sf_data <= {fcnt_r, ch};
            sf_parity_err <= perr[ch];
            sf_status_bit <= cs_bit;
            sf_user_bit <= ch;
            block_start_pulse <= !ch && (fcnt_r % BLOCK == 0);
        end else begin
            sf_channel <= ~sf_channel;
            sf_data <= ~sf_data;
            sf_parity_err <= ~sf_parity_err;
            sf_status_bit <= ~sf_status_bit;
            sf_user_bit <= ~sf_user_bit;
            block_start_pulse <= ~block_start_pulse;
        end
    end
endmodule : audio_src_model
`default_nettype wire

// ### verification/tb_spdif_conceal_rate.sv
// self-checking bench for the receiver block
`timescale 1ns/1ps
`include "spdif_rx_map.svh"
`default_nettype none
module tb_spdif_conceal_rate
    import spdif_rx_pkg::*;
;
    logic clk, rst_n, hsel, hwrite, ref_en, lock_en, cs_bit;
    logic [31:0] haddr, hwdata;
    logic [1:0] htrans, perr, npcm = 2'b00;
    logic [11:0] period;
    logic [23:0] good [2] = '{24'h0, 24'h0};
    logic [23:0] exp_d;
    logic exp_ch, aud_pend = 1'b0;
    int failures = 0, n_tests = 0, cyc = 0, fidx = 2, k;
    wire logic hreadyout, hresp, audio_valid, audio_channel, error_out;
    wire logic [31:0] hrdata;
    wire logic [23:0] audio_data, sf_data;
    wire logic status_bit_output, user_bit_output, use_free_running;
    wire logic rate_code_bit_high, rate_code_bit_low, reference_clock_input;
    wire logic frame_clock, bit_clock, pll_lock, sf_valid, sf_channel;
    wire logic sf_parity_err, sf_status_bit, sf_user_bit, block_start_pulse;
    wire logic [31:0] aud_w = {6'h0, audio_valid, audio_channel, audio_data};
    wire rate_code_t rate = {rate_code_bit_high, rate_code_bit_low};
    wire logic [31:0] rate_w = {30'h0, rate};
    wire logic [31:0] misc_w = {30'h0, error_out, use_free_running};
    wire logic [31:0] cu_w = {30'h0, status_bit_output, user_bit_output};

    spdif_conceal_rate dut_u (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
        .hrdata, .reference_clock_input, .frame_clock, .bit_clock,
        .pll_lock, .sf_valid, .sf_channel, .sf_data, .sf_parity_err,
        .sf_status_bit, .sf_user_bit, .block_start_pulse, .audio_valid,
        .audio_channel, .audio_data, .status_bit_output, .user_bit_output,
        .error_out, .rate_code_bit_high, .rate_code_bit_low,
        .use_free_running);

    audio_src_model #(.BLOCK(4)) src_u (.clk, .rst_n, .period, .ref_en,
        .lock_en, .cs_bit, .perr, .reference_clock_input, .frame_clock,
        .bit_clock, .pll_lock, .sf_valid, .sf_channel, .sf_data,
        .sf_parity_err, .sf_status_bit, .sf_user_bit, .block_start_pulse);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one bus word: address phase, then data phase
    task automatic ahb_cycle(input logic [7:0] a, input logic wr,
                             input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
    endtask : ahb_cycle

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        ahb_cycle(a, 1'b0, 32'h0);
        chk(hrdata, exp);
    endtask : rdchk

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 98000) begin
            failures++;
            conclude;
        end
    end

    // audio reference model
    always @(posedge clk) begin
        if (aud_pend) chk(aud_w, {7'h1, exp_ch, exp_d});
        aud_pend = 1'b0;
        if (rst_n && sf_valid) begin
            exp_ch = sf_channel;
            exp_d = (sf_parity_err && !npcm[exp_ch]) ? good[exp_ch] : sf_data;
            if (!sf_parity_err) good[exp_ch] = sf_data;
            if (block_start_pulse && !exp_ch) fidx = 0;
            else if (!exp_ch) fidx++;
            if (fidx == 1) npcm[exp_ch] = sf_status_bit;
            aud_pend = 1'b1;
        end
    end

    initial begin
        {hsel, hwrite, ref_en, lock_en, cs_bit} = 5'h00;
        {haddr, hwdata, htrans, perr} = 68'h0;
        period = 12'd1280;
        rst_n = 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (300) @(posedge clk);
        chk(rate_w, {30'h0, `RATE_RESET});
        rdchk(`REG_CTRL, `CTRL_RESET);
        rdchk(`REG_STATUS, 32'h0000_000c);
        rdchk(8'h0c, 32'h0);
        ref_en <= 1'b1;
        repeat (50) @(posedge clk);
        chk(rate_w, {30'h0, `RATE_ABNORMAL});
        chk(misc_w, 32'h3);
        lock_en <= 1'b1;
        repeat (5120) @(posedge clk);
        chk(misc_w, 32'h0);
        perr <= 2'b01;
        repeat (1000) @(posedge clk);
        chk(misc_w, 32'h3);
        repeat (1920) @(posedge clk);
        perr <= 2'b00;
        cs_bit <= 1'b1;
        repeat (7680) @(posedge clk);
        perr <= 2'b11;
        repeat (2560) @(posedge clk);
        perr <= 2'b00;
        @(posedge frame_clock);
        repeat (300) @(posedge clk);
        chk(cu_w, 32'h2);
        repeat (100) @(posedge clk);
        chk(cu_w, 32'h3);
        ahb_cycle(`REG_CTRL, 1'b1, 32'h0);
        rdchk(`REG_CTRL, 32'h0);
        ahb_cycle(8'h0c, 1'b1, 32'hffff_ffff);
        rdchk(8'h0c, 32'h0);
        ahb_cycle(`REG_CTRL, 1'b1, `CTRL_RESET);
        k = 0;
        while (rate === `RATE_ABNORMAL && k < 95000) begin
            @(posedge clk);
            k++;
        end
        chk(rate_w, {30'h0, `RATE_48K});
        rdchk(`REG_STATUS, 32'h0000_00f1);
        repeat (1280) @(posedge clk);
        chk(rate_w, {30'h0, `RATE_48K});
        ref_en <= 1'b0;
        repeat (300) @(posedge clk);
        chk(rate_w, {30'h0, `RATE_48K});
        rdchk(`REG_STATUS, 32'h0000_00d1);
        period <= 12'd1600;
        k = 0;
        while (error_out !== 1'b1 && k < 4000) begin
            @(posedge clk);
            k++;
        end
        chk({31'h0, error_out}, 32'h1);
        chk(rate_w, {30'h0, `RATE_48K});
        lock_en <= 1'b0;
        ref_en <= 1'b1;
        period <= 12'd1280;
        repeat (50) @(posedge clk);
        chk(rate_w, {30'h0, `RATE_ABNORMAL});
        ahb_cycle(`REG_CTRL, 1'b1, 32'h0);
        repeat (5) @(posedge clk);
        chk(misc_w, 32'h2);
        conclude;
    end
endmodule : tb_spdif_conceal_rate
`default_nettype wire
